// File: hdl/tcps_pkg.sv
// Constants shared by the timer clock prescale and select block.
package tcps_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] TCPS_ADDR_TIMER_CONFIG = 4'h0;
  localparam logic [3:0] TCPS_ADDR_STATUS       = 4'h1;
  localparam logic [7:0] TCPS_TIMER_CONFIG_RST  = 8'h00;
  localparam logic [7:0] TCPS_RD_UNMAPPED       = 8'h00;

  // ==========================================================================
  // Field positions of timer_config
  // ==========================================================================
  localparam int TCPS_COUNT_SOURCE_SELECT_BIT = 0;
  localparam int TCPS_EDGE_SELECT_LSB         = 1;
  localparam int TCPS_EDGE_SELECT_W           = 2;
  localparam int TCPS_DUAL8_MODE_BIT          = 3;
  localparam int TCPS_CLOCK_DIVIDE_SELECT_LSB = 4;
  localparam int TCPS_CLOCK_DIVIDE_SELECT_W   = 3;
  localparam int TCPS_ALT_CLOCK_SELECT_BIT    = 7;

  // ==========================================================================
  // Edge choices for the external count input
  // ==========================================================================
  localparam logic [1:0] TCPS_EDGE_NONE    = 2'h0;
  localparam logic [1:0] TCPS_EDGE_RISING  = 2'h1;
  localparam logic [1:0] TCPS_EDGE_FALLING = 2'h2;
  localparam logic [1:0] TCPS_EDGE_BOTH    = 2'h3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int TCPS_SYS_CLK_HZ       = 20_000_000;
  localparam int TCPS_ALT_CLK_HZ       = 32_768;
  localparam int TCPS_MIN_SAMPLE_RATIO = 4;
  // Least number of system cycles between two sampled alternate clock edges.
  localparam int TCPS_ALT_MIN_GAP_CYC  = TCPS_MIN_SAMPLE_RATIO;

endpackage

// File: hdl/tcps_sync.sv
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
module tcps_sync
  import tcps_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } tcps_sync_st_t;

  tcps_sync_st_t st;
  tcps_sync_st_t next_st;

  // ==========================================================================
  // Stages
  // ==========================================================================
  // The first stage feeds only the second, so a metastable level never fans out.
  always_comb begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule

// File: hdl/tcps_top.sv
// Timer clock source select and power-of-two prescaler with its register port.
`timescale 1ns/100ps
module tcps_top
  import tcps_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic       alt_clk,
  input  wire logic       ext_pin,
  output logic      [7:0] rd_data,
  output logic            timer_tick,
  output logic            count_source_select,
  output logic      [1:0] edge_select,
  output logic            dual8_mode
);

  localparam int CW = 7;

  typedef struct packed {
    logic [7:0]    cfg;
    logic [CW-1:0] cnt;
    logic          alt_prev;
    logic          ext_prev;
    logic          tick;
    logic [7:0]    rd_data;
  } tcps_st_t;

  tcps_st_t st;
  tcps_st_t next_st;

  logic [1:0]    pins_sync;
  logic          alt_lvl;
  logic          ext_lvl;
  logic [2:0]    div_sel;
  logic [CW-1:0] div_limit;
  logic          alt_sel;
  logic          csel;
  logic [1:0]    esel;
  logic          alt_rise;
  logic          ext_rise;
  logic          ext_fall;
  logic          src_tick;
  logic          ext_evt;
  logic          pre_tick;
  logic          tick_ev;

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  // Both pins come from outside the system clock domain.
  tcps_sync #(
    .W (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in ({ext_pin, alt_clk}),
    .sync_out (pins_sync)
  );

  assign alt_lvl = pins_sync[0];
  assign ext_lvl = pins_sync[1];

  // ==========================================================================
  // Source and prescale decode
  // ==========================================================================
  // Fields of the configuration register and the derived edge events.
  always_comb begin
    div_sel   = st.cfg[TCPS_CLOCK_DIVIDE_SELECT_LSB +: TCPS_CLOCK_DIVIDE_SELECT_W];
    alt_sel   = st.cfg[TCPS_ALT_CLOCK_SELECT_BIT];
    csel      = st.cfg[TCPS_COUNT_SOURCE_SELECT_BIT];
    esel      = st.cfg[TCPS_EDGE_SELECT_LSB +: TCPS_EDGE_SELECT_W];
    div_limit = CW'((8'h01 << div_sel) - 8'h01);
    // The slow clock is seen only through its sampled rising edge, which is why
    // it must be several system cycles long per phase.
    alt_rise  = alt_lvl & ~st.alt_prev;
    ext_rise  = ext_lvl & ~st.ext_prev;
    ext_fall  = ~ext_lvl & st.ext_prev;
    // Timer mode source: every system cycle or every alternate clock rising edge.
    src_tick  = alt_sel ? alt_rise : 1'b1;
    ext_evt   = 1'b0;
    if (esel == TCPS_EDGE_RISING) begin
      ext_evt = ext_rise;
    end else if (esel == TCPS_EDGE_FALLING) begin
      ext_evt = ext_fall;
    end else if (esel == TCPS_EDGE_BOTH) begin
      ext_evt = ext_rise | ext_fall;
    end
    // A shortened divide setting must not leave the count above the new limit.
    pre_tick  = src_tick && (st.cnt >= div_limit);
    tick_ev   = csel ? ext_evt : pre_tick;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Prescale count, tick enable, register writes and registered read data.
  always_comb begin
    next_st          = st;
    next_st.alt_prev = alt_lvl;
    next_st.ext_prev = ext_lvl;
    next_st.tick     = tick_ev;
    // The prescaler is idle in counter mode, so a return to timer mode starts clean.
    if (csel) begin
      next_st.cnt = '0;
    end else if (src_tick) begin
      next_st.cnt = pre_tick ? '0 : st.cnt + CW'(1);
    end
    if (wr_en) begin
      if (addr == TCPS_ADDR_TIMER_CONFIG) begin
        next_st.cfg = wr_data;
      end
    end
    if (rd_en) begin
      if (addr == TCPS_ADDR_TIMER_CONFIG) begin
        next_st.rd_data = st.cfg;
      end else if (addr == TCPS_ADDR_STATUS) begin
        next_st.rd_data = {st.cnt, alt_lvl};
      end else begin
        next_st.rd_data = TCPS_RD_UNMAPPED;
      end
    end else begin
      next_st.rd_data = 8'h00;
    end
  end

  // State register; reset clears the configuration and all counting state.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st     <= '0;
      st.cfg <= TCPS_TIMER_CONFIG_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rd_data             = st.rd_data;
  assign timer_tick          = st.tick;
  assign count_source_select = st.cfg[TCPS_COUNT_SOURCE_SELECT_BIT];
  assign edge_select         = st.cfg[TCPS_EDGE_SELECT_LSB +: TCPS_EDGE_SELECT_W];
  assign dual8_mode          = st.cfg[TCPS_DUAL8_MODE_BIT];

  // ==========================================================================
  // Checks
  // ==========================================================================
  // A full prescale period in timer mode always ends in a tick.
  property p_div_period;
    @(posedge clk_sys) disable iff (!nrst)
      (!csel && src_tick && st.cnt == div_limit && !wr_en) |=> timer_tick;
  endproperty
  a_div_period: assert property (p_div_period) else $error("prescale period did not tick");

  // A tick in timer mode comes only when the count had reached two to the divide code less one.
  property p_div_ratio;
    @(posedge clk_sys) disable iff (!nrst)
      (timer_tick && !$past(csel) && !$past(wr_en, 2))
        |-> $past(st.cnt) >= CW'((8'h01 << $past(div_sel)) - 8'h01);
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("tick before prescale limit");

  // In counter mode each selected edge gives a tick with no division.
  property p_count_direct;
    @(posedge clk_sys) disable iff (!nrst)
      (csel && ext_evt) |=> timer_tick;
  endproperty
  a_count_direct: assert property (p_count_direct) else $error("edge count was divided");

  // With the alternate clock chosen, timer mode ticks need a sampled edge.
  property p_alt_source;
    @(posedge clk_sys) disable iff (!nrst)
      (!csel && alt_sel && !alt_rise) |=> !timer_tick;
  endproperty
  a_alt_source: assert property (p_alt_source) else $error("tick without alternate edge");

  // Sampled alternate edges are separated by the least sampling gap.
  property p_alt_gap;
    @(posedge clk_sys) disable iff (!nrst)
      alt_rise |=> !alt_rise [*3];
  endproperty
  a_alt_gap: assert property (p_alt_gap) else $error("alternate clock too fast");

  // Counter mode holds the prescaler at zero.
  property p_counter_mode;
    @(posedge clk_sys) disable iff (!nrst)
      csel |=> st.cnt == '0;
  endproperty
  a_counter_mode: assert property (p_counter_mode) else $error("prescaler ran in counter mode");

  // The configuration reads zero at the first edge after reset release.
  property p_cfg_reset;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(nrst) |-> st.cfg == TCPS_TIMER_CONFIG_RST;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config not cleared by reset");

  // Each tick has its cause in the cycle before.
  property p_tick_cause;
    @(posedge clk_sys) disable iff (!nrst)
      timer_tick |-> $past(tick_ev);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("tick without event");

  // A read returns the configuration in the following cycle.
  property p_read_cfg;
    @(posedge clk_sys) disable iff (!nrst)
      (rd_en && addr == TCPS_ADDR_TIMER_CONFIG && !wr_en) |=> rd_data == $past(st.cfg);
  endproperty
  a_read_cfg: assert property (p_read_cfg) else $error("config read mismatch");

  c_div_max: cover property (@(posedge clk_sys) disable iff (!nrst)
    timer_tick && div_sel == 3'h7 && !csel);
  c_alt_tick: cover property (@(posedge clk_sys) disable iff (!nrst)
    timer_tick && alt_sel && !csel);
  c_count_tick: cover property (@(posedge clk_sys) disable iff (!nrst)
    timer_tick && csel && esel == TCPS_EDGE_BOTH);

endmodule

// File: dv/tcps_top_bench.sv
// Self-checking bench for the timer clock select and prescaler block.
`timescale 1ns/100ps
module tcps_top_bench
  import tcps_pkg::*;
;
  logic       clk_sys    = 1'b0;
  logic       nrst       = 1'b0;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wr_data    = 8'h00;
  logic       wr_en      = 1'b0;
  logic       rd_en      = 1'b0;
  logic       alt_clk    = 1'b0;
  logic       ext_pin    = 1'b0;
  logic       alt_run    = 1'b0;
  logic [7:0] rd_data;
  logic       timer_tick;
  logic       count_source_select;
  logic [1:0] edge_select;
  logic       dual8_mode;
  int         errors     = 0;
  int         num_checks = 0;
  int         tick_cnt   = 0;
  int         alt_cnt    = 0;

  // ==========================================================================
  // Clock, alternate clock and tick counting
  // ==========================================================================
  always #25 clk_sys = ~clk_sys;

  // Eight system cycles per alternate period, twice the least ratio allowed.
  always @(posedge clk_sys) begin
    if (alt_run) begin
      alt_cnt <= (alt_cnt == 3) ? 0 : alt_cnt + 1;
      if (alt_cnt == 3) begin
        alt_clk <= ~alt_clk;
      end
    end
  end

  // Ticks are counted at every edge so that edge counting needs no polling.
  always @(posedge clk_sys) begin
    if (timer_tick === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  tcps_top u_tcps_top (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .addr                (addr),
    .wr_data             (wr_data),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .alt_clk             (alt_clk),
    .ext_pin             (ext_pin),
    .rd_data             (rd_data),
    .timer_tick          (timer_tick),
    .count_source_select (count_source_select),
    .edge_select         (edge_select),
    .dual8_mode          (dual8_mode)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // Counts cycles up to the next tick; a missing tick ends the run.
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (timer_tick !== 1'b1 && n < 600);
    if (n >= 600) begin
      errors++;
      $display("BAD tick wait expected tick seen none");
      tally_and_finish();
    end
  endtask

  // The first two ticks after a change are dropped, as the count may start mid-period.
  task automatic measure_gap(output int gap);
    wait_tick(gap);
    wait_tick(gap);
    wait_tick(gap);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_reset();
    logic [7:0] d;
    bus_read(TCPS_ADDR_TIMER_CONFIG, d);
    check("config after reset", d, TCPS_TIMER_CONFIG_RST);
    check("fields after reset", {4'h0, dual8_mode, edge_select, count_source_select}, 8'h00);
    bus_read(4'hF, d);
    check("unmapped read", d, TCPS_RD_UNMAPPED);
    bus_write(TCPS_ADDR_TIMER_CONFIG, 8'hFF);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    bus_read(TCPS_ADDR_TIMER_CONFIG, d);
    check("config after second reset", d, 8'h00);
    $display("done reset");
  endtask

  task automatic test_fields();
    logic [7:0] d;
    bus_write(TCPS_ADDR_TIMER_CONFIG, 8'h0D);
    bus_read(TCPS_ADDR_TIMER_CONFIG, d);
    check("config readback", d, 8'h0D);
    check("counter mode fields", {4'h0, dual8_mode, edge_select, count_source_select}, 8'h0D);
    bus_write(TCPS_ADDR_TIMER_CONFIG, 8'h0A);
    // The write lands at the edge the task returns on, so the fields are looked at just after.
    #1;
    check("timer mode fields", {4'h0, dual8_mode, edge_select, count_source_select}, 8'h0A);
    $display("done fields");
  endtask

  task automatic test_divide();
    int gap;
    for (int d = 0; d < 8; d++) begin
      bus_write(TCPS_ADDR_TIMER_CONFIG, {1'b0, 3'(d), 4'h0});
      measure_gap(gap);
      check("system divide gap", gap[7:0], 8'(1 << d));
    end
    $display("done divide");
  endtask

  // The largest divide code is set, so any prescaling would swallow the edges.
  task automatic test_counter();
    int         exp;
    logic [7:0] d;
    for (int e = 0; e < 4; e++) begin
      bus_write(TCPS_ADDR_TIMER_CONFIG, {4'h7, 1'b0, 2'(e), 1'b1});
      repeat (4) @(posedge clk_sys);
      #1;
      // The prescaler is held at zero and the alternate clock is still low here.
      bus_read(TCPS_ADDR_STATUS, d);
      check("status in counter mode", d, 8'h00);
      tick_cnt = 0;
      repeat (5) begin
        @(posedge clk_sys);
        ext_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ext_pin <= 1'b0;
        repeat (5) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
      #1;
      exp = (e == 0) ? 0 : (e == 3) ? 10 : 5;
      check("edge tick count", 8'(tick_cnt), 8'(exp));
    end
    $display("done counter");
  endtask

  task automatic test_alt();
    int gap;
    alt_run = 1'b1;
    for (int d = 0; d < 3; d += 2) begin
      bus_write(TCPS_ADDR_TIMER_CONFIG, {1'b1, 3'(d), 4'h0});
      measure_gap(gap);
      check("alternate divide gap", gap[7:0], 8'(8 << d));
    end
    alt_run = 1'b0;
    $display("done alternate");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    test_reset();
    test_fields();
    test_divide();
    test_counter();
    test_alt();
    tally_and_finish();
  end
endmodule
